// ---- adct_pkg.sv ----
// Package for the converter timing block: selects, counts, carriers and states
`default_nettype none
package adct_pkg;
    localparam int          RESULT_WIDTH   = 10;
    localparam int          WORD_WIDTH     = 16;
    localparam int          CONV_STEPS     = 40;
    localparam int          LOAD_CPU_CYC   = 2;
    localparam int          CAL_BC_PERIODS = 3328;
    localparam logic [15:0] RESULT_RESET   = 16'h0000;
    localparam logic [9:0]  RESULT_ZERO    = 10'h000;
    localparam logic [9:0]  RESULT_FULL    = 10'h3FF;
    localparam int          DIVSEL_POS     = 14;
    localparam int          SAMPSEL_POS    = 12;
    localparam int          DIV_BY_4       = 4;
    localparam int          DIV_BY_2       = 2;
    localparam int          DIV_BY_16      = 16;
    localparam int          DIV_BY_8       = 8;
    localparam int          SAMP_8         = 8;
    localparam int          SAMP_16        = 16;
    localparam int          SAMP_32        = 32;
    localparam int          SAMP_64        = 64;

    typedef struct packed {
        logic [1:0] basicClockDividerSelect;
        logic [1:0] sampleLengthSelect;
    } adct_ctrl_t;

    typedef struct packed {
        logic       belowGround;
        logic       aboveSupply;
        logic [9:0] code;
    } adct_sample_t;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_SAMPLE = 4'h2,
        ST_CONV   = 4'h4,
        ST_LOAD   = 4'h8
    } adct_state_t;
endpackage
`default_nettype wire

// ---- adct_clock_divider.sv ----
// Basic clock enable generator: one-cycle pulse every selected CPU clocks
`default_nettype none
module adct_clock_divider (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [1:0] divSelect,
    output var  logic       bcTick
);
    logic [3:0] count;
    logic [3:0] terminal;

    always_comb begin
        case (divSelect)
            2'h0:    terminal = 4'(adct_pkg::DIV_BY_4 - 1);
            2'h1:    terminal = 4'(adct_pkg::DIV_BY_2 - 1);
            2'h2:    terminal = 4'(adct_pkg::DIV_BY_16 - 1);
            default: terminal = 4'(adct_pkg::DIV_BY_8 - 1);
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset || count >= terminal) begin
            count <= 4'h0;
        end else begin
            count <= count + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            bcTick <= 1'b0;
        end else begin
            bcTick <= (count >= terminal);
        end
    end
endmodule
`default_nettype wire

// ---- adc_conversion_timing.sv ----
// Conversion sequencer: sample phase, 40 steps, result load, reset calibration
`default_nettype none
module adc_conversion_timing #(
    parameter int CAL_PERIODS = adct_pkg::CAL_BC_PERIODS
) (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic [15:0]          converterControlWord,
    input  wire logic                 startConversion,
    input  wire adct_pkg::adct_sample_t analogIn,
    output var  logic [15:0]          resultWord,
    output var  logic                 conversionDone,
    output var  logic                 busy,
    output var  logic                 sampling,
    output var  logic                 calibrating
);
    adct_pkg::adct_ctrl_t   ctrl;
    adct_pkg::adct_state_t  state;
    adct_pkg::adct_sample_t held;
    adct_pkg::adct_sample_t inSync1;
    adct_pkg::adct_sample_t inSync2;
    logic                   startSync1;
    logic                   startSync2;
    logic                   startPrev;
    logic                   startEdge;
    logic                   startPending;
    logic                   bcTick;
    logic [6:0]             phaseCount;
    logic [6:0]             sampleLast;
    logic                   loadCount;
    logic [12:0]            calCount;
    logic [9:0]             resultCode;

    assign ctrl.basicClockDividerSelect = converterControlWord[adct_pkg::DIVSEL_POS +: 2];
    assign ctrl.sampleLengthSelect      = converterControlWord[adct_pkg::SAMPSEL_POS +: 2];

    adct_clock_divider u_div (
        .clk       (clk),
        .reset     (reset),
        .divSelect (ctrl.basicClockDividerSelect),
        .bcTick    (bcTick)
    );

    always_comb begin
        case (ctrl.sampleLengthSelect)
            2'h0:    sampleLast = 7'(adct_pkg::SAMP_8 - 1);
            2'h1:    sampleLast = 7'(adct_pkg::SAMP_16 - 1);
            2'h2:    sampleLast = 7'(adct_pkg::SAMP_32 - 1);
            default: sampleLast = 7'(adct_pkg::SAMP_64 - 1);
        endcase
    end

    // Pin-side inputs are synchronised before use
    always_ff @(posedge clk) begin
        inSync1    <= analogIn;
        inSync2    <= inSync1;
        startSync1 <= startConversion;
        startSync2 <= startSync1;
        startPrev  <= reset ? 1'b0 : startSync2;
    end

    assign startEdge = startSync2 && !startPrev;

    // A taken start waits for a basic tick so the sample phase spans whole periods
    always_ff @(posedge clk) begin
        if (reset || state != adct_pkg::ST_IDLE || bcTick) begin
            startPending <= 1'b0;
        end else if (startEdge) begin
            startPending <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state      <= adct_pkg::ST_IDLE;
            phaseCount <= 7'h00;
            loadCount  <= 1'b0;
        end else begin
            case (state)
                adct_pkg::ST_IDLE: begin
                    if ((startEdge || startPending) && bcTick) begin
                        state      <= adct_pkg::ST_SAMPLE;
                        phaseCount <= 7'h00;
                    end
                end
                adct_pkg::ST_SAMPLE: begin
                    if (bcTick) begin
                        if (phaseCount == sampleLast) begin
                            state      <= adct_pkg::ST_CONV;
                            phaseCount <= 7'h00;
                        end else begin
                            phaseCount <= phaseCount + 7'h01;
                        end
                    end
                end
                adct_pkg::ST_CONV: begin
                    if (bcTick) begin
                        if (phaseCount == 7'(adct_pkg::CONV_STEPS - 1)) begin
                            state     <= adct_pkg::ST_LOAD;
                            loadCount <= 1'b0;
                        end else begin
                            phaseCount <= phaseCount + 7'h01;
                        end
                    end
                end
                adct_pkg::ST_LOAD: begin
                    if (loadCount == 1'(adct_pkg::LOAD_CPU_CYC - 1)) begin
                        state <= adct_pkg::ST_IDLE;
                    end else begin
                        loadCount <= loadCount + 1'b1;
                    end
                end
                default: state <= adct_pkg::ST_IDLE;
            endcase
        end
    end

    // Input tracked only while sampling, frozen afterwards
    always_ff @(posedge clk) begin
        if (reset) begin
            held <= '0;
        end else if (state == adct_pkg::ST_SAMPLE) begin
            held <= inSync2;
        end
    end

    always_comb begin
        if (held.belowGround) begin
            resultCode = adct_pkg::RESULT_ZERO;
        end else if (held.aboveSupply) begin
            resultCode = adct_pkg::RESULT_FULL;
        end else begin
            resultCode = held.code;
        end
    end

    logic loadNow;
    assign loadNow = (state == adct_pkg::ST_LOAD) && (loadCount == 1'(adct_pkg::LOAD_CPU_CYC - 1));

    always_ff @(posedge clk) begin
        if (reset) begin
            resultWord     <= adct_pkg::RESULT_RESET;
            conversionDone <= 1'b0;
        end else begin
            conversionDone <= loadNow;
            if (loadNow) begin
                resultWord[adct_pkg::RESULT_WIDTH-1:0] <= resultCode;
            end
        end
    end

    // Calibration counts basic periods only when no conversion is running
    always_ff @(posedge clk) begin
        if (reset) begin
            calCount    <= 13'h0000;
            calibrating <= 1'b1;
        end else if (calibrating && bcTick && state == adct_pkg::ST_IDLE) begin
            if (calCount == 13'(CAL_PERIODS - 1)) begin
                calibrating <= 1'b0;
            end else begin
                calCount <= calCount + 13'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            busy     <= 1'b0;
            sampling <= 1'b0;
        end else begin
            busy     <= (state != adct_pkg::ST_IDLE);
            sampling <= (state == adct_pkg::ST_SAMPLE);
        end
    end

    AST_DONE_ON_LOAD: assert property (@(posedge clk) disable iff (reset)
        loadNow |=> conversionDone) else $error("done not raised after load");
    AST_DONE_ONE_CYCLE: assert property (@(posedge clk) disable iff (reset)
        conversionDone |=> !conversionDone) else $error("done longer than one cycle");
    AST_HELD_STABLE: assert property (@(posedge clk) disable iff (reset)
        (state == adct_pkg::ST_CONV) |=> $stable(held)) else $error("sample changed after sample phase");
    AST_CONV_TO_LOAD: assert property (@(posedge clk) disable iff (reset)
        (state == adct_pkg::ST_CONV && $past(state) == adct_pkg::ST_SAMPLE) |-> ##[1:700]
        (state == adct_pkg::ST_LOAD)) else $error("conversion steps overrun");
    AST_LOAD_TWO: assert property (@(posedge clk) disable iff (reset)
        (state == adct_pkg::ST_LOAD && $past(state) == adct_pkg::ST_CONV) |=>
        (state == adct_pkg::ST_LOAD) ##1 (state == adct_pkg::ST_IDLE)) else $error("load not two cycles");
    AST_CLAMP_LOW: assert property (@(posedge clk) disable iff (reset)
        (loadNow && held.belowGround) |=> resultWord[9:0] == adct_pkg::RESULT_ZERO) else $error("low clamp");
    AST_CLAMP_HIGH: assert property (@(posedge clk) disable iff (reset)
        (loadNow && !held.belowGround && held.aboveSupply) |=> resultWord[9:0] == adct_pkg::RESULT_FULL)
        else $error("high clamp");
    AST_CODE_PASS: assert property (@(posedge clk) disable iff (reset)
        (loadNow && !held.belowGround && !held.aboveSupply) |=> resultWord[9:0] == $past(held.code))
        else $error("in-range code not loaded");
    AST_UPPER_KEPT: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> $stable(resultWord[15:10])) else $error("upper result bits changed");
    AST_CAL_PAUSE: assert property (@(posedge clk) disable iff (reset)
        (state != adct_pkg::ST_IDLE) |=> $stable(calCount)) else $error("calibration ran during conversion");
    AST_SAMPLE_TICKS: assert property (@(posedge clk) disable iff (reset)
        (state == adct_pkg::ST_SAMPLE && !bcTick) |=> $stable(phaseCount)) else $error("sample count moved");
    AST_ENTER_ON_TICK: assert property (@(posedge clk) disable iff (reset)
        (state == adct_pkg::ST_IDLE && !bcTick) |=> (state == adct_pkg::ST_IDLE))
        else $error("sample phase began between basic ticks");
    AST_PENDING_IDLE: assert property (@(posedge clk) disable iff (reset)
        startPending |-> (state == adct_pkg::ST_IDLE)) else $error("start held pending while busy");
    AST_CAL_STAYS_DONE: assert property (@(posedge clk) disable iff (reset)
        !calibrating |=> !calibrating) else $error("calibration restarted without reset");

    COV_CONVERSION: cover property (@(posedge clk) disable iff (reset) conversionDone);
    COV_CAL_END: cover property (@(posedge clk) disable iff (reset) $fell(calibrating));
    COV_CONV_IN_CAL: cover property (@(posedge clk) disable iff (reset) calibrating && conversionDone);
    COV_CLAMP: cover property (@(posedge clk) disable iff (reset) loadNow && held.aboveSupply);
    COV_PENDING: cover property (@(posedge clk) disable iff (reset) startPending);
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking testbench for the converter timing sequencer
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CAL = 20;
    logic                   clk = 1'b0;
    logic                   reset = 1'b1;
    logic [15:0]            ctrlWord = 16'h0000;
    logic                   startConv = 1'b0;
    adct_pkg::adct_sample_t ain = '0;
    logic [15:0]            resultWord;
    logic                   conversionDone;
    logic                   busy;
    logic                   sampling;
    logic                   calibrating;
    int                     fail_count = 0;
    int                     n_compared = 0;
    int                     cyc = 0;
    int                     doneCount = 0;
    int                     lastDone = 0;
    logic [31:0]            rng = 32'h00004B18;
    logic [15:0]            expQ[$];
    int                     calLen;

    adc_conversion_timing #(.CAL_PERIODS(CAL)) u_dut (
        .clk                  (clk),
        .reset                (reset),
        .converterControlWord (ctrlWord),
        .startConversion      (startConv),
        .analogIn             (ain),
        .resultWord           (resultWord),
        .conversionDone       (conversionDone),
        .busy                 (busy),
        .sampling             (sampling),
        .calibrating          (calibrating)
    );

    always #25 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // Clamp model: ground wins over supply, upper bits stay zero
    function automatic logic [15:0] model(input adct_pkg::adct_sample_t s);
        if (s.belowGround) return 16'h0000;
        if (s.aboveSupply) return 16'h03FF;
        return {6'h00, s.code};
    endfunction

    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (conversionDone === 1'b1) begin
            doneCount <= doneCount + 1;
            lastDone <= cyc;
            if (expQ.size() == 0) check(1'b0, "completion without request");
            else check(resultWord === expQ.pop_front(), "result word");
        end
    end

    task automatic do_reset();
        startConv <= 1'b0;
        reset <= 1'b1;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
    endtask

    // One conversion; the input is scrambled once sampling has ended
    task automatic convert(input logic [1:0] dv, input logic [1:0] sp, input int kind);
        int n, s, t0, d0, i, tS, sLen;
        adct_pkg::adct_sample_t smp;
        n = (dv == 2'b00) ? 4 : (dv == 2'b01) ? 2 : (dv == 2'b10) ? 16 : 8;
        s = 8 << sp;
        rng = xs(rng);
        smp = '{belowGround: kind[0], aboveSupply: kind[1], code: rng[9:0]};
        ctrlWord <= {dv, sp, rng[27:16]};
        ain <= smp;
        expQ.push_back(model(smp));
        d0 = doneCount;
        @(posedge clk);
        startConv <= 1'b1;
        t0 = cyc;
        for (i = 0; i < 3000 && sampling !== 1'b1; i++) @(posedge clk);
        tS = cyc;
        for (i = 0; i < 3000 && sampling !== 1'b0; i++) @(posedge clk);
        sLen = i;
        repeat (3) @(posedge clk);
        rng = xs(rng);
        ain <= rng[11:0];
        startConv <= 1'b0;
        @(posedge clk);
        startConv <= 1'b1;
        for (i = 0; i < 6000 && doneCount == d0; i++) @(posedge clk);
        check(lastDone - t0 >= (s + 40) * n + 6, "conversion too short");
        check(lastDone - t0 <= (s + 40) * n + n + 5, "conversion too long");
        check(lastDone - tS == (s + 40) * n + 1, "conversion time not fixed");
        check(sLen == s * n, "sample phase length");
        startConv <= 1'b0;
        repeat (n + 6) @(posedge clk);
        check(busy === 1'b0 && doneCount == d0 + 1, "start while busy acted on");
    endtask

    task automatic measure_cal();
        calLen = 0;
        while (calibrating !== 1'b0 && calLen < 8000) begin
            @(posedge clk);
            calLen++;
        end
    endtask

    initial begin
        do_reset();
        @(posedge clk);
        check(resultWord === 16'h0000 && busy === 1'b0 && calibrating === 1'b1, "reset state");
        measure_cal();
        check(calLen >= CAL * 4 - 2 && calLen <= CAL * 4 + 8, "calibration length");
        // A 20 MHz clock divided by 2 would exceed the basic clock limit, so that select is swapped for /8
        for (int k = 0; k < 16; k++) convert((k[3:2] == 2'b01) ? 2'b11 : k[3:2], k[1:0], k % 4);
        do_reset();
        fork
            convert(2'b00, 2'b00, 0);
            measure_cal();
        join
        check(calLen >= CAL * 4 + 48 * 4 - 4 && calLen <= CAL * 4 + 48 * 4 + 16, "calibration extension");
        print_verdict();
    end

    initial begin
        #(50 * 30000);
        fail_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
